// *** design/pm_port_pkg.sv ***
/*
 * Constants for the parallel program memory port: widths, chip select codes,
 * wait-state step and reset values.
 * Assumes a single 100 MHz system clock and a synchronous active-high reset.
 */
package pm_port_pkg;
    localparam int          DATA_W      = 16;
    localparam int          ADDR_W      = 24;
    localparam int          WAIT_W      = 5;
    localparam int          SEL_W       = 2;
    localparam int          STEP_W      = 8;
    localparam int          CLK_PERIOD_NS  = 10;
    localparam int          WAIT_STEP_TIME_NS = 6;
    // One step must not be shorter than 6ns, so round the cycle count up
    localparam int          STEP_CYCLES =
        (WAIT_STEP_TIME_NS * 10 + CLK_PERIOD_NS * 10 - 1) / (CLK_PERIOD_NS * 10) < 1 ? 1 :
        (WAIT_STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [STEP_W-1:0] STEP_LAST = STEP_W'(STEP_CYCLES - 1);
    localparam logic [SEL_W-1:0]  SEL_BOOT  = 2'h0;
    localparam logic [SEL_W-1:0]  SEL_AUX   = 2'h1;
    localparam logic [SEL_W-1:0]  SEL_PERIPH = 2'h2;
    localparam logic [WAIT_W-1:0] WAIT_MIN  = 5'h01;
    localparam logic [WAIT_W-1:0] WAIT_RST  = 5'h1f;
    localparam logic [2:0]        SELS_IDLE = 3'h7;
endpackage

// *** design/program_memory_parallel_flash_port.sv ***
/*
 * Parallel asynchronous program memory port: three selects, 16-bit data,
 * read and three-phase write cycles timed by programmed wait counts.
 * Assumes req is taken only while ready is high; inputs are synchronous.
 */
module program_memory_parallel_flash_port (
    input  wire logic                             sys_clk,
    input  wire logic                             sys_rst,
    input  wire logic                             req,
    input  wire logic                             req_write,
    input  wire logic [pm_port_pkg::SEL_W-1:0]    req_sel,
    input  wire logic [pm_port_pkg::ADDR_W-1:0]   req_addr,
    input  wire logic [pm_port_pkg::DATA_W-1:0]   req_wdata,
    input  wire logic [pm_port_pkg::WAIT_W-1:0]   read_wait,
    input  wire logic [pm_port_pkg::WAIT_W-1:0]   write_setup_wait,
    input  wire logic [pm_port_pkg::WAIT_W-1:0]   write_pulse_wait,
    input  wire logic [pm_port_pkg::WAIT_W-1:0]   write_hold_wait,
    output logic                                  ready,
    output logic                                  rdata_valid,
    output logic [pm_port_pkg::DATA_W-1:0]        rdata,
    output logic                                  boot_mem_select_n,
    output logic                                  aux_flash_select_n,
    output logic                                  periph_select_n,
    output logic                                  output_enable_n,
    output logic                                  write_strobe_n,
    output logic [pm_port_pkg::ADDR_W-2:0]        mem_addr,
    output logic                                  addr_top_gpio,
    output logic [pm_port_pkg::DATA_W-1:0]        mem_data_out,
    output logic                                  mem_data_oe,
    input  wire logic [pm_port_pkg::DATA_W-1:0]   mem_data_in
);
    typedef enum logic [2:0] {IDLE, RD, WR_SETUP, WR_PULSE, WR_HOLD} state_t;

    ////////////////////////////////////////////////////////////////////////////
    state_t                          state_q, state_d;
    logic [2:0]                      sels_q, sels_d;
    logic                            oe_n_q, oe_n_d;
    logic                            we_n_q, we_n_d;
    logic                            doe_q, doe_d;
    logic [pm_port_pkg::ADDR_W-1:0]  addr_q, addr_d;
    logic [pm_port_pkg::DATA_W-1:0]  wdat_q, wdat_d;
    logic [pm_port_pkg::DATA_W-1:0]  rdat_q, rdat_d;
    logic                            rv_q, rv_d;
    logic                            t_start;
    logic [pm_port_pkg::WAIT_W-1:0]  t_count;
    logic                            t_done;
    logic                            take;
    logic [2:0]                      take_sels;

    wait_step_timer u_timer (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .start   (t_start),
        .count   (t_count),
        .done    (t_done)
    );

    // One-hot low select; an out-of-range code selects nothing
    function automatic logic [2:0] decode_sel(input logic [pm_port_pkg::SEL_W-1:0] s);
        logic [2:0] v;
        v = pm_port_pkg::SELS_IDLE;
        case (s)
            pm_port_pkg::SEL_BOOT:   v = 3'h6;
            pm_port_pkg::SEL_AUX:    v = 3'h5;
            pm_port_pkg::SEL_PERIPH: v = 3'h3;
            default:                 v = pm_port_pkg::SELS_IDLE;
        endcase
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Accept only in idle and only for a code that selects a device
    assign take_sels = decode_sel(req_sel);
    assign take      = (state_q == IDLE) && req && (take_sels != pm_port_pkg::SELS_IDLE);

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer: phase order and the timer loads
    always_comb begin
        state_d = state_q;
        t_start = 1'b0;
        t_count = read_wait;
        case (state_q)
            IDLE: begin
                if (take) begin
                    t_start = 1'b1;
                    if (req_write) begin
                        t_count = write_setup_wait;
                        state_d = WR_SETUP;
                    end else begin
                        t_count = read_wait;
                        state_d = RD;
                    end
                end
            end
            RD: begin
                if (t_done) begin
                    state_d = IDLE;
                end
            end
            WR_SETUP: begin
                if (t_done) begin
                    t_start = 1'b1;
                    t_count = write_pulse_wait;
                    state_d = WR_PULSE;
                end
            end
            WR_PULSE: begin
                if (t_done) begin
                    t_start = 1'b1;
                    t_count = write_hold_wait;
                    state_d = WR_HOLD;
                end
            end
            WR_HOLD: begin
                if (t_done) begin
                    state_d = IDLE;
                end
            end
            default: begin
                state_d = IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_q <= IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin strobes: every one is a flop so no glitch reaches the memories
    always_comb begin
        sels_d = sels_q;
        oe_n_d = oe_n_q;
        we_n_d = we_n_q;
        doe_d  = doe_q;
        case (state_q)
            IDLE: begin
                if (take) begin
                    sels_d = take_sels;
                    // A read releases the data bus; a write drives it from the start
                    oe_n_d = req_write;
                    doe_d  = req_write;
                end
            end
            RD: begin
                if (t_done) begin
                    oe_n_d = 1'b1;
                    sels_d = pm_port_pkg::SELS_IDLE;
                end
            end
            WR_SETUP: begin
                if (t_done) begin
                    we_n_d = 1'b0;
                end
            end
            WR_PULSE: begin
                if (t_done) begin
                    we_n_d = 1'b1;
                end
            end
            WR_HOLD: begin
                if (t_done) begin
                    sels_d = pm_port_pkg::SELS_IDLE;
                    doe_d  = 1'b0;
                end
            end
            default: begin
                sels_d = pm_port_pkg::SELS_IDLE;
                oe_n_d = 1'b1;
                we_n_d = 1'b1;
                doe_d  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sels_q <= pm_port_pkg::SELS_IDLE;
            oe_n_q <= 1'b1;
            we_n_q <= 1'b1;
            doe_q  <= 1'b0;
        end else begin
            sels_q <= sels_d;
            oe_n_q <= oe_n_d;
            we_n_q <= we_n_d;
            doe_q  <= doe_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Address and data path
    always_comb begin
        addr_d = addr_q;
        wdat_d = wdat_q;
        rdat_d = rdat_q;
        rv_d   = 1'b0;
        if (take) begin
            addr_d = req_addr;
            if (req_write) begin
                wdat_d = req_wdata;
            end
        end
        // Sampled while output enable is still low
        if (state_q == RD && t_done) begin
            rdat_d = mem_data_in;
            rv_d   = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            addr_q <= '0;
            wdat_q <= '0;
            rdat_q <= '0;
            rv_q   <= 1'b0;
        end else begin
            addr_q <= addr_d;
            wdat_q <= wdat_d;
            rdat_q <= rdat_d;
            rv_q   <= rv_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign ready              = (state_q == IDLE);
    assign rdata_valid        = rv_q;
    assign rdata              = rdat_q;
    assign boot_mem_select_n  = sels_q[0];
    assign aux_flash_select_n = sels_q[1];
    assign periph_select_n    = sels_q[2];
    assign output_enable_n    = oe_n_q;
    assign write_strobe_n     = we_n_q;
    assign mem_addr           = addr_q[pm_port_pkg::ADDR_W-2:0];
    assign addr_top_gpio      = addr_q[pm_port_pkg::ADDR_W-1];
    assign mem_data_out       = wdat_q;
    assign mem_data_oe        = doe_q;
endmodule

// *** design/wait_step_timer.sv ***
/*
 * Counts a programmed number of wait-state steps and pulses done.
 * Assumes start is a one-cycle pulse issued only while idle.
 */
module wait_step_timer (
    input  wire logic                              sys_clk,
    input  wire logic                              sys_rst,
    input  wire logic                              start,
    input  wire logic [pm_port_pkg::WAIT_W-1:0]    count,
    output logic                                   done
);
    logic [pm_port_pkg::WAIT_W-1:0] left_q, left_d;
    logic [pm_port_pkg::STEP_W-1:0] tick_q, tick_d;
    logic                           busy_q, busy_d;
    logic                           done_d;

    always_comb begin
        left_d = left_q;
        tick_d = tick_q;
        busy_d = busy_q;
        done_d = 1'b0;
        if (start) begin
            // Zero would wrap the down-count to 32 steps
            left_d = (count == '0) ? pm_port_pkg::WAIT_MIN : count;
            tick_d = '0;
            busy_d = 1'b1;
        end else if (busy_q) begin
            if (tick_q == pm_port_pkg::STEP_LAST) begin
                tick_d = '0;
                if (left_q == pm_port_pkg::WAIT_MIN) begin
                    busy_d = 1'b0;
                    done_d = 1'b1;
                end else begin
                    left_d = left_q - pm_port_pkg::WAIT_MIN;
                end
            end else begin
                tick_d = tick_q + 8'h01;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            left_q <= '0;
            tick_q <= '0;
            busy_q <= 1'b0;
            done   <= 1'b0;
        end else begin
            left_q <= left_d;
            tick_q <= tick_d;
            busy_q <= busy_d;
            done   <= done_d;
        end
    end
endmodule

// *** dv/flash_model.sv ***
/* Behavioural parallel NOR flash on the far side of the port.
   Data is good only acc_cycles after output enable; stores the last write. */
module flash_model (
    input wire logic        sys_clk,
    input wire logic [2:0]  sel_n,
    input wire logic        output_enable_n,
    input wire logic        write_strobe_n,
    input wire logic [23:0] addr,
    input wire logic [15:0] wdata,
    input wire logic        wdata_oe,
    input wire logic [7:0]  acc_cycles,
    output logic [15:0]     rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0]  oe_cnt = 8'h00;
    logic [15:0] word;
    logic [2:0]  cap_sel_n;
    logic [23:0] cap_addr;
    logic [15:0] cap_data;
    // Content mixes select and address so a wrong decode shows
    assign word = {addr[23], addr[14:0]} ^ {13'h0, sel_n} ^ 16'h5a3c;
    // Too early or released: inverse word, never a lucky match
    assign rdata = (!output_enable_n && sel_n != 3'h7 && oe_cnt >= acc_cycles) ?
                   word : ~word;
    always @(posedge sys_clk) oe_cnt <= output_enable_n ? 8'h00 : oe_cnt + 8'h01;
    always @(posedge write_strobe_n) begin
        cap_sel_n <= sel_n;
        cap_addr <= addr;
        cap_data <= wdata_oe ? wdata : ~wdata;
    end
endmodule

// *** dv/pm_port_asserts.sv ***
/* Pin-level checker for the program memory port.
   Bound into the port top; assumes wait counts are held during an access. */
module pm_port_asserts (
    input wire logic        sys_clk,
    input wire logic        sys_rst,
    input wire logic        rdata_valid,
    input wire logic        boot_mem_select_n,
    input wire logic        aux_flash_select_n,
    input wire logic        periph_select_n,
    input wire logic        output_enable_n,
    input wire logic        write_strobe_n,
    input wire logic [15:0] mem_data_out,
    input wire logic        mem_data_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    wire logic [2:0] sel_n = {periph_select_n, aux_flash_select_n, boot_mem_select_n};
    wire logic       any_sel = (sel_n != 3'h7);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////
    property p_one_sel;
        $onehot0(~sel_n);
    endproperty
    a_one_sel: assert property (p_one_sel) else $error("two selects low");
    property p_rst_idle;
        $past(sys_rst) |-> !any_sel && output_enable_n && write_strobe_n && !mem_data_oe;
    endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("not idle after reset");
    property p_excl;
        !(!output_enable_n && !write_strobe_n);
    endproperty
    a_excl: assert property (p_excl) else $error("read and write strobes together");
    property p_rd_nodrv;
        !output_enable_n |-> !mem_data_oe && any_sel;
    endproperty
    a_rd_nodrv: assert property (p_rd_nodrv) else $error("bus driven in read");
    property p_setup;
        $fell(write_strobe_n) |-> $past(any_sel, 2) && $past(mem_data_oe, 2);
    endproperty
    a_setup: assert property (p_setup) else $error("strobe before setup");
    property p_pulse;
        $fell(write_strobe_n) |=> !write_strobe_n;
    endproperty
    a_pulse: assert property (p_pulse) else $error("strobe pulse short");
    property p_hold;
        $rose(write_strobe_n) |-> (any_sel && mem_data_oe) [*2];
    endproperty
    a_hold: assert property (p_hold) else $error("hold too short");
    property p_wdata;
        !write_strobe_n |-> mem_data_oe && $stable(mem_data_out);
    endproperty
    a_wdata: assert property (p_wdata) else $error("data moved under strobe");
    property p_rd_min;
        $fell(output_enable_n) |=> !output_enable_n;
    endproperty
    a_rd_min: assert property (p_rd_min) else $error("read too short");
    property p_valid;
        rdata_valid |-> !$past(output_enable_n);
    endproperty
    a_valid: assert property (p_valid) else $error("valid without read");
    property p_valid_one;
        rdata_valid |=> !rdata_valid;
    endproperty
    a_valid_one: assert property (p_valid_one) else $error("valid longer than a cycle");
endmodule
bind program_memory_parallel_flash_port pm_port_asserts u_chk (.sys_clk, .sys_rst,
    .rdata_valid, .boot_mem_select_n, .aux_flash_select_n, .periph_select_n,
    .output_enable_n, .write_strobe_n, .mem_data_out, .mem_data_oe);

// *** dv/testbench.sv ***
/* Self-checking bench for the program memory port.
   Requests driven at the rising edge; a flash model answers on the far side. */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk = 1'b0, sys_rst = 1'b1, req = 1'b0, req_write = 1'b0;
    logic [1:0]  req_sel = 2'h0;
    logic [23:0] req_addr = 24'h0;
    logic [15:0] req_wdata = 16'h0;
    logic [4:0]  rw = 5'h1, sw = 5'h1, pw = 5'h1, hw = 5'h1;
    logic [7:0]  acc = 8'h0;
    logic        ready, rdata_valid, oe_n, we_n, data_oe, top;
    logic [15:0] rdata, dout, din;
    logic [2:0]  sel_n;
    logic [22:0] maddr;
    int          n_fail = 0, n_checks = 0, cyc = 0;
    program_memory_parallel_flash_port dut (.sys_clk, .sys_rst, .req, .req_write, .req_sel,
        .req_addr, .req_wdata, .read_wait(rw), .write_setup_wait(sw), .write_pulse_wait(pw),
        .write_hold_wait(hw), .ready, .rdata_valid, .rdata, .boot_mem_select_n(sel_n[0]),
        .aux_flash_select_n(sel_n[1]), .periph_select_n(sel_n[2]), .output_enable_n(oe_n),
        .write_strobe_n(we_n), .mem_addr(maddr), .addr_top_gpio(top), .mem_data_out(dout),
        .mem_data_oe(data_oe), .mem_data_in(din));
    flash_model fm (.sys_clk, .sel_n, .output_enable_n(oe_n), .write_strobe_n(we_n),
        .addr({top, maddr}), .wdata(dout), .wdata_oe(data_oe), .acc_cycles(acc), .rdata(din));
    ////////////////////////////////////////
    always #5 sys_clk = ~sys_clk;
    // Worst access is about 100 cycles; 45 accesses fit well inside
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic int eff(logic [4:0] w); return (w == 5'h0) ? 1 : int'(w); endfunction
    function automatic logic [2:0] sel_exp(logic [1:0] s); return 3'h7 ^ (3'h1 << s); endfunction
    // Model content: address folded with the select code
    function automatic logic [15:0] word_exp(logic [1:0] s, logic [23:0] a);
        return {a[23], a[14:0]} ^ {13'h0, sel_exp(s)} ^ 16'h5a3c;
    endfunction
    ////////////////////////////////////////
    // w packs read, setup, pulse and hold waits; timings counted from the taken edge
    task automatic access(logic wr, logic [1:0] sel, logic [23:0] a, logic [15:0] d,
                          logic [19:0] w, logic [7:0] ac);
        int t, ts, tf, tr, te, tv;
        ts = 0;
        tf = 0;
        tr = 0;
        te = 0;
        tv = 0;
        @(posedge sys_clk);
        req <= 1'b1;
        req_write <= wr;
        req_sel <= sel;
        req_addr <= a;
        req_wdata <= d;
        {rw, sw, pw, hw} <= w;
        acc <= ac;
        @(posedge sys_clk);
        req <= 1'b0;
        for (t = 1; t < 120 && te == 0; t++) begin
            @(posedge sys_clk);
            #1;
            if (sel_n !== 3'h7 && ts == 0) begin
                ts = t;
                check("select", sel_n, sel_exp(sel));
                check("address", {top, maddr}, a);
            end
            if (sel_n !== 3'h7) check("ready", ready, 1'b0);
            if (we_n === 1'b0 && tf == 0) tf = t;
            if (we_n === 1'b1 && tf != 0 && tr == 0) tr = t;
            if (rdata_valid === 1'b1) begin
                tv = t;
                check("rdata", rdata, word_exp(sel, a));
            end
            if (ts != 0 && sel_n === 3'h7) te = t;
        end
        if (sel == 2'h3) check("refused", 32'(ts), 32'h0);
        else if (wr) begin
            // Select fell on the taken edge, one edge before the loop first looks
            check("setup", 32'(tf - ts + 1), 32'(eff(w[14:10]) + 1));
            check("pulse", 32'(tr - tf), 32'(eff(w[9:5]) + 1));
            check("hold", 32'(te - tr), 32'(eff(w[4:0]) + 1));
            check("wdata", fm.cap_data, d);
            check("wtarget", {fm.cap_sel_n, fm.cap_addr}, {sel_exp(sel), a});
        end else check("rtime", 32'(tv), 32'(eff(w[19:15]) + 1));
    endtask
    initial begin
        void'($urandom(32'hd62eb79a));
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        #1;
        check("idle", {ready, sel_n, oe_n, we_n, data_oe}, 7'h7e);
        access(1'b0, 2'h0, 24'h800001, 16'h0, 20'h0, 8'h1);
        access(1'b1, 2'h1, 24'h7fffff, 16'hffff, 20'h0, 8'h0);
        access(1'b1, 2'h2, 24'h0, 16'h1234, 20'hfffff, 8'h0);
        access(1'b0, 2'h2, 24'h123456, 16'h0, 20'hfffff, 8'h1f);
        access(1'b0, 2'h3, 24'h0, 16'h0, 20'h0, 8'h0);
        repeat (40) access(1'($urandom), 2'($urandom % 3), 24'($urandom), 16'($urandom),
                           20'($urandom), 8'($urandom & 1));
        end_of_test();
    end
endmodule
